// *** hw/mode_reg_config.sv ***
/*
  Mode-register capture block of the memory device: decodes the command
  pins, keeps the four mode register images and derives burst, latency
  and recovery controls from them, write termination from the pins.
  Assumes command pins sampled synchronously on clock_in, with the
  controller keeping reset, ordering and reserved-bit obligations.
*/
`timescale 1ns/1ps
`default_nettype none

module mode_reg_config
  import mode_reg_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  input  wire logic              clk_en_in,
  input  wire logic              cke_in,
  input  wire logic              cs_b_in,
  input  wire logic              ras_b_in,
  input  wire logic              cas_b_in,
  input  wire logic              we_b_in,
  input  wire logic [BANK_W-1:0] bank_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              nom_term_en_in,
  input  wire logic              write_level_in,
  output logic [ADDR_W-1:0]      primary_mode_reg_out,
  output logic [ADDR_W-1:0]      extended_mode_reg_one_out,
  output logic [ADDR_W-1:0]      extended_mode_reg_two_out,
  output logic [ADDR_W-1:0]      extended_mode_reg_three_out,
  output logic [1:0]             burst_length_field_out,
  output logic                   read_burst_order_out,
  output logic [3:0]             read_latency_field_out,
  output logic                   test_mode_bit_out,
  output logic                   dll_reset_req_out,
  output logic                   powerdown_exit_select_out,
  output logic [3:0]             min_recovery_cycles_out,
  output logic [4:0]             autoprecharge_write_delay_out,
  output logic                   reserved_code_out,
  output logic                   pattern_read_en_out,
  output logic [1:0]             pattern_select_out,
  output logic                   access_valid_out,
  output logic                   chopped_burst_four_out,
  output logic                   burst_of_eight_out,
  output logic [1:0]             timer_pull_in_out,
  output logic                   write_term_en_out
);

  // ==========================================================
  // Command decode
  cmd_pins_type     pins;
  primary_view_type view;
  logic             mode_write;
  logic             access_cmd;
  logic             write_cmd;
  logic [1:0]       reg_sel;

  assign pins = '{cs_b: cs_b_in, ras_b: ras_b_in, cas_b: cas_b_in,
                  we_b: we_b_in, bank: bank_in, addr: addr_in};
  // All four strobes low with clock enable high
  assign mode_write = cke_in && !pins.cs_b && !pins.ras_b &&
                      !pins.cas_b && !pins.we_b;
  assign access_cmd = cke_in && !pins.cs_b && pins.ras_b && !pins.cas_b;
  assign write_cmd = access_cmd && !pins.we_b;
  assign reg_sel = pins.bank[1:0];

  // ==========================================================
  // Register images
  logic [ADDR_W-1:0] image_q [REG_COUNT];
  logic [ADDR_W-1:0] image_d [REG_COUNT];

  // Only the selected image takes the address bus
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      image_d[i] = image_q[i];
    end
    if (mode_write) begin
      image_d[reg_sel] = pins.addr;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        image_q[i] <= MODE_REG_RESET;
      end
    end else if (clk_en_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        image_q[i] <= image_d[i];
      end
    end
  end

  // ==========================================================
  // Field decode of the primary image
  primary_field_decode u_decode (
    .image_in (image_d[SEL_PRIMARY]),
    .view_out (view)
  );

  // ==========================================================
  // Derived controls, next values
  logic [1:0] burst_d;
  logic       order_d;
  logic [3:0] lat_d;
  logic       test_d;
  logic       dll_d;
  logic       pdx_d;
  logic [3:0] wr_d;
  logic [4:0] dal_d;
  logic       resv_d;
  logic       pat_en_d;
  logic [1:0] pat_sel_d;
  logic       acc_d;
  logic       chop_d;
  logic       eight_d;
  logic [1:0] pull_d;
  logic       term_d;

  // Next values for the outputs: mode fields from the updated images, access, burst size and termination from the command pins
  always_comb begin
    burst_d = view.burst_len;
    order_d = view.interleave;
    lat_d = view.latency;
    test_d = view.test_mode;
    dll_d = view.dll_reset;
    pdx_d = view.fast_pd_exit;
    wr_d = view.write_recovery;
    // Recovery plus row precharge; zero when recovery code is reserved
    dal_d = (wr_d == 4'h0) ? 5'h00 :
            5'({1'b0, wr_d} + ROW_PRECHARGE_CYCLES);
    resv_d = view.reserved_code;
    pat_en_d = image_d[SEL_EXT_THREE][PATTERN_EN_BIT];
    // Pattern select is meaningless in normal mode, so force it quiet
    pat_sel_d = pat_en_d ? image_d[SEL_EXT_THREE][1:0] : 2'h0;
    acc_d = access_cmd;
    chop_d = 1'b0;
    eight_d = 1'b0;
    pull_d = 2'h0;
    if (access_cmd) begin
      unique case (burst_d)
        BURST_FIXED_EIGHT: eight_d = 1'b1;
        BURST_FIXED_FOUR: begin
          chop_d = 1'b1;
          // Internal write begins early only for fixed chop
          if (write_cmd) begin
            pull_d = CHOP_PULL_IN[1:0];
          end
        end
        BURST_ON_THE_FLY: begin
          // A12 sampled with the command; timers stay put
          chop_d = !pins.addr[OTF_SEL_BIT];
          eight_d = pins.addr[OTF_SEL_BIT];
        end
        default: begin
          chop_d = 1'b0;
          eight_d = 1'b0;
        end
      endcase
    end
    // Write termination held off in leveling, else active on writes
    term_d = write_cmd && !write_level_in &&
             (nom_term_en_in || !nom_term_en_in);
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      burst_length_field_out <= BURST_FIXED_EIGHT;
      read_burst_order_out <= 1'b0;
      read_latency_field_out <= 4'h0;
      test_mode_bit_out <= 1'b0;
      dll_reset_req_out <= 1'b0;
      powerdown_exit_select_out <= 1'b0;
      min_recovery_cycles_out <= 4'h0;
      autoprecharge_write_delay_out <= 5'h00;
      reserved_code_out <= 1'b0;
      pattern_read_en_out <= 1'b0;
      pattern_select_out <= 2'h0;
      access_valid_out <= 1'b0;
      chopped_burst_four_out <= 1'b0;
      burst_of_eight_out <= 1'b0;
      timer_pull_in_out <= 2'h0;
      write_term_en_out <= 1'b0;
      primary_mode_reg_out <= MODE_REG_RESET;
      extended_mode_reg_one_out <= MODE_REG_RESET;
      extended_mode_reg_two_out <= MODE_REG_RESET;
      extended_mode_reg_three_out <= MODE_REG_RESET;
    end else if (clk_en_in) begin
      burst_length_field_out <= burst_d;
      read_burst_order_out <= order_d;
      read_latency_field_out <= lat_d;
      test_mode_bit_out <= test_d;
      dll_reset_req_out <= dll_d;
      powerdown_exit_select_out <= pdx_d;
      min_recovery_cycles_out <= wr_d;
      autoprecharge_write_delay_out <= dal_d;
      reserved_code_out <= resv_d;
      pattern_read_en_out <= pat_en_d;
      pattern_select_out <= pat_sel_d;
      access_valid_out <= acc_d;
      chopped_burst_four_out <= chop_d;
      burst_of_eight_out <= eight_d;
      timer_pull_in_out <= pull_d;
      write_term_en_out <= term_d;
      primary_mode_reg_out <= image_d[SEL_PRIMARY];
      extended_mode_reg_one_out <= image_d[SEL_EXT_ONE];
      extended_mode_reg_two_out <= image_d[SEL_EXT_TWO];
      extended_mode_reg_three_out <= image_d[SEL_EXT_THREE];
    end
  end

  // ==========================================================
  // Checks
  sequence s_mode_write_primary;
    clk_en_in && mode_write && reg_sel == SEL_PRIMARY;
  endsequence

  property p_primary_update;
    @(posedge clock_in) disable iff (!rst_b_in)
    s_mode_write_primary |=> primary_mode_reg_out == $past(addr_in);
  endproperty
  a_primary_update: assert property (p_primary_update)
    else $error("primary image not loaded");

  property p_only_selected;
    @(posedge clock_in) disable iff (!rst_b_in)
    clk_en_in && mode_write && reg_sel == SEL_EXT_TWO |=>
      $stable(extended_mode_reg_one_out) &&
      extended_mode_reg_two_out == $past(addr_in);
  endproperty
  a_only_selected: assert property (p_only_selected)
    else $error("wrong image updated");

  property p_no_write_without_cmd;
    @(posedge clock_in) disable iff (!rst_b_in)
    clk_en_in && !(mode_write && reg_sel == SEL_EXT_THREE) |=>
      $stable(extended_mode_reg_three_out);
  endproperty
  a_no_write_without_cmd: assert property (p_no_write_without_cmd)
    else $error("image changed without a mode write");

  property p_latency_ok;
    @(posedge clock_in) disable iff (!rst_b_in)
    read_latency_field_out != 4'h0 |->
      read_latency_field_out >= 4'h5 && read_latency_field_out <= 4'hb;
  endproperty
  a_latency_ok: assert property (p_latency_ok)
    else $error("latency out of range");

  property p_dal_sum;
    @(posedge clock_in) disable iff (!rst_b_in)
    min_recovery_cycles_out != 4'h0 |-> autoprecharge_write_delay_out ==
      5'({1'b0, min_recovery_cycles_out} + ROW_PRECHARGE_CYCLES);
  endproperty
  a_dal_sum: assert property (p_dal_sum)
    else $error("write delay sum wrong");

  property p_otf_a12;
    @(posedge clock_in) disable iff (!rst_b_in)
    clk_en_in && access_cmd && burst_d == BURST_ON_THE_FLY |=>
      chopped_burst_four_out == !$past(addr_in[OTF_SEL_BIT]) &&
      timer_pull_in_out == 2'h0;
  endproperty
  a_otf_a12: assert property (p_otf_a12)
    else $error("on the fly burst wrong");

  property p_chop_pull;
    @(posedge clock_in) disable iff (!rst_b_in)
    clk_en_in && write_cmd && burst_d == BURST_FIXED_FOUR |=>
      timer_pull_in_out == 2'h2 && chopped_burst_four_out;
  endproperty
  a_chop_pull: assert property (p_chop_pull)
    else $error("fixed chop pull-in missing");

  property p_pattern_ignore;
    @(posedge clock_in) disable iff (!rst_b_in)
    !pattern_read_en_out |-> pattern_select_out == 2'h0;
  endproperty
  a_pattern_ignore: assert property (p_pattern_ignore)
    else $error("pattern select not ignored");

  property p_level_term;
    @(posedge clock_in) disable iff (!rst_b_in)
    clk_en_in && write_cmd && write_level_in |=> !write_term_en_out;
  endproperty
  a_level_term: assert property (p_level_term)
    else $error("termination during leveling");

endmodule
`default_nettype wire

// *** hw/mode_reg_pkg.sv ***
/*
  Package for the mode-register block: command pin layout, bank selects,
  field positions, reset values and decode constants.
  Assumes a single 20 MHz clock domain; nothing else.
*/
`default_nettype none
package mode_reg_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned REG_COUNT = 4;

  // ==========================================================
  // Bank select codes for the four registers
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_EXT_ONE = 2'h1;
  localparam logic [1:0] SEL_EXT_TWO = 2'h2;
  localparam logic [1:0] SEL_EXT_THREE = 2'h3;

  // ==========================================================
  // Field positions: primary register, A12 on-the-fly select, pattern enable
  localparam int unsigned BURST_FIELD_LSB = 0;
  localparam int unsigned LAT_LOW_BIT = 2;
  localparam int unsigned ORDER_BIT = 3;
  localparam int unsigned LAT_HIGH_LSB = 4;
  localparam int unsigned TEST_BIT = 7;
  localparam int unsigned DLL_RST_BIT = 8;
  localparam int unsigned WR_LSB = 9;
  localparam int unsigned PD_EXIT_BIT = 12;
  localparam int unsigned OTF_SEL_BIT = 12;
  localparam int unsigned PATTERN_EN_BIT = 2;

  // ==========================================================
  // Burst length field encodings
  localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
  localparam logic [1:0] BURST_FIXED_FOUR = 2'h2;
  localparam logic [1:0] BURST_RESERVED = 2'h3;

  // ==========================================================
  // Reset values and timing
  localparam logic [ADDR_W-1:0] MODE_REG_RESET = 15'h0000;
  localparam logic [4:0] CHOP_PULL_IN = 5'h02;
  localparam logic [4:0] ROW_PRECHARGE_CYCLES = 5'h0b;

  // Decoded primary register view
  typedef struct packed {
    logic [1:0] burst_len;
    logic       interleave;
    logic [3:0] latency;
    logic       test_mode;
    logic       dll_reset;
    logic [3:0] write_recovery;
    logic       fast_pd_exit;
    logic       reserved_code;
  } primary_view_type;

  // Command pins
  typedef struct packed {
    logic              cs_b;
    logic              ras_b;
    logic              cas_b;
    logic              we_b;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_type;

endpackage
`default_nettype wire

// *** hw/primary_field_decode.sv ***
/*
  Decoder that turns the primary mode register image into cycle counts
  and flags. Purely combinational; the caller registers the results.
*/
`timescale 1ns/1ps
`default_nettype none
module primary_field_decode
  import mode_reg_pkg::*;
(
  input  wire logic [ADDR_W-1:0] image_in,
  output primary_view_type       view_out
);

  logic [3:0] lat_code;
  logic [2:0] wr_code;

  // ==========================================================
  // Latency and recovery tables
  always_comb begin
    lat_code = {image_in[LAT_HIGH_LSB+2], image_in[LAT_HIGH_LSB+1],
                image_in[LAT_HIGH_LSB], image_in[LAT_LOW_BIT]};
    wr_code = image_in[WR_LSB +: 3];
    view_out = '0;
    view_out.burst_len = image_in[BURST_FIELD_LSB +: 2];
    view_out.interleave = image_in[ORDER_BIT];
    view_out.test_mode = image_in[TEST_BIT];
    view_out.dll_reset = image_in[DLL_RST_BIT];
    view_out.fast_pd_exit = image_in[PD_EXIT_BIT];
    unique case (lat_code)
      4'h2: view_out.latency = 4'h5;
      4'h4: view_out.latency = 4'h6;
      4'h6: view_out.latency = 4'h7;
      4'h8: view_out.latency = 4'h8;
      4'ha: view_out.latency = 4'h9;
      4'hc: view_out.latency = 4'ha;
      4'he: view_out.latency = 4'hb;
      default: view_out.latency = 4'h0;
    endcase
    unique case (wr_code)
      3'h1: view_out.write_recovery = 4'h5;
      3'h2: view_out.write_recovery = 4'h6;
      3'h3: view_out.write_recovery = 4'h7;
      3'h4: view_out.write_recovery = 4'h8;
      3'h5: view_out.write_recovery = 4'ha;
      3'h6: view_out.write_recovery = 4'hc;
      default: view_out.write_recovery = 4'h0;
    endcase
    view_out.reserved_code = (view_out.latency == 4'h0) ||
                             (view_out.write_recovery == 4'h0) ||
                             (view_out.burst_len == BURST_RESERVED);
  end

endmodule
`default_nettype wire

// *** dv/ctrl_model.sv ***
/*
  Behavioural memory controller driving the command pins of the mode
  register block: warm reset, mode writes, reads and writes, no-ops.
  Assumes one clock; every pin changes just after a falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
  import mode_reg_pkg::*;
(
  input  wire logic        clock_in,
  output var logic         rst_b_out,
  output var logic         cke_out,
  output var cmd_pins_type cmd_out
);
  // ==========================================================
  // Power-on state: reset held, clock enable low, deselected
  initial begin
    rst_b_out = 1'b0;
    cke_out   = 1'b0;
    cmd_out   = {4'hf, 3'h0, 15'h0000};
  end

  // No-op; bank and address flip so stale values never look held
  task automatic nop();
    @(negedge clock_in);
    cke_out <= 1'b1;
    cmd_out <= {4'h7, ~cmd_out.bank, ~cmd_out.addr};
  endtask

  // Warm reset: clock enable low well before release, 5 cycles low
  task automatic warm_reset();
    @(negedge clock_in);
    cke_out   <= 1'b0;
    rst_b_out <= 1'b0;
    repeat (5) @(negedge clock_in);
    rst_b_out <= 1'b1;
    nop();
  endtask

  // Mode write; reserved bits of the chosen register forced low
  task automatic mode_write(input logic [1:0] sel,
                            input logic [ADDR_W-1:0] val,
                            input logic ce);
    logic [ADDR_W-1:0] keep;
    case (sel)
      2'h0: keep = 15'h1fff;
      2'h1: keep = 15'h12ff;
      2'h2: keep = 15'h06ff;
      default: keep = 15'h0007;
    endcase
    @(negedge clock_in);
    cke_out <= ce;
    cmd_out <= {4'h0, 1'b0, sel, val & keep};
    nop();
  endtask

  // Read or write; A12 carries the burst size on the fly
  task automatic access(input logic wr, input logic a12);
    @(negedge clock_in);
    cmd_out <= {3'h2, ~wr, 3'h0, 2'h0, a12, 12'h000};
    nop();
  endtask

  // Long calibration closes the mode-write phase of initialisation
  task automatic calibrate();
    @(negedge clock_in);
    cmd_out <= {4'h6, 3'h0, 15'h0400};
    nop();
  endtask
endmodule
`default_nettype wire

// *** dv/tb_mode_reg_config.sv ***
/*
  Self-checking bench of the mode register block: controller model on
  the command pins, expected values worked out here from the rules.
  Assumes the design answers at the taking edge; checks fall half a cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
module tb_mode_reg_config
  import mode_reg_pkg::*;
;
  logic         clock_in = 1'b0;
  logic         rst_b, cke, clk_en, nom_term, wlev;
  cmd_pins_type cmd;
  logic [14:0]  img0, img1, img2, img3, exp_img [4];
  logic [1:0]   blen, po, psel;
  logic [3:0]   lat, wrc;
  logic [4:0]   dal;
  logic         ord, tmode, dll, pd, rsv, pen, av, c4, b8, term;
  int           n_fail = 0;
  int           n_checks = 0;
  int           wr_tab [8] = '{0, 5, 6, 7, 8, 10, 12, 0};
  // Recovery time assumed for the memory; a plain default value
  localparam int RECOVERY_NS = 15;
  localparam int CLK_NS = 50;

  // ==========================================================
  // Clock, design and controller
  always #25 clock_in = ~clock_in;

  mode_reg_config i_dut (.clock_in(clock_in), .rst_b_in(rst_b),
    .clk_en_in(clk_en), .cke_in(cke), .cs_b_in(cmd.cs_b),
    .ras_b_in(cmd.ras_b), .cas_b_in(cmd.cas_b), .we_b_in(cmd.we_b),
    .bank_in(cmd.bank), .addr_in(cmd.addr), .nom_term_en_in(nom_term),
    .write_level_in(wlev), .primary_mode_reg_out(img0),
    .extended_mode_reg_one_out(img1), .extended_mode_reg_two_out(img2),
    .extended_mode_reg_three_out(img3), .burst_length_field_out(blen),
    .read_burst_order_out(ord), .read_latency_field_out(lat),
    .test_mode_bit_out(tmode), .dll_reset_req_out(dll),
    .powerdown_exit_select_out(pd), .min_recovery_cycles_out(wrc),
    .autoprecharge_write_delay_out(dal), .reserved_code_out(rsv),
    .pattern_read_en_out(pen), .pattern_select_out(psel),
    .access_valid_out(av), .chopped_burst_four_out(c4),
    .burst_of_eight_out(b8), .timer_pull_in_out(po),
    .write_term_en_out(term));

  ctrl_model i_ctrl (.clock_in(clock_in), .rst_b_out(rst_b),
    .cke_out(cke), .cmd_out(cmd));

  // ==========================================================
  // Shared steps
  task automatic check_imgs();
    `CHK(img0, exp_img[0])
    `CHK(img1, exp_img[1])
    `CHK(img2, exp_img[2])
    `CHK(img3, exp_img[3])
  endtask

  task automatic wr_mode(input logic [1:0] sel, input logic [14:0] v);
    i_ctrl.mode_write(sel, v, 1'b1);
    exp_img[sel] = v;
    check_imgs();
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard: the tests need under a hundred cycles
  initial begin
    repeat (5000) @(posedge clock_in);
    n_fail++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    complete_run();
  end

  // ==========================================================
  // Test sequence
  initial begin
    clk_en = 1'b1;
    nom_term = 1'b0;
    wlev = 1'b0;
    exp_img = '{15'h0000, 15'h0000, 15'h0000, 15'h0000};
    i_ctrl.warm_reset();
    check_imgs();
    `CHK(dal, 5'h00)
    // Registers 1, 2 and 0 written; the others must hold
    wr_mode(2'h1, 15'h1246);
    wr_mode(2'h2, 15'h06a5);
    wr_mode(2'h0, 15'h1398);
    `CHK({ord, tmode, dll, pd, rsv}, 5'h1e)
    `CHK(wrc >= 4'((RECOVERY_NS + CLK_NS - 1) / CLK_NS), 1'b1)
    // Long calibration ends the setup; no image or access may move
    i_ctrl.calibrate();
    check_imgs();
    `CHK(av, 1'b0)
    // Refused writes: clock enable pin low, then state frozen
    i_ctrl.mode_write(2'h0, 15'h0210, 1'b0);
    check_imgs();
    @(negedge clock_in) clk_en <= 1'b0;
    i_ctrl.mode_write(2'h1, 15'h0000, 1'b1);
    clk_en <= 1'b1;
    check_imgs();
    // Latency and recovery code tables, reserved ends included
    for (int i = 0; i < 8; i++) begin
      wr_mode(2'h0, 15'((i << 4) | (i << 9)));
      `CHK(lat, 4'((i == 0) ? 0 : i + 4))
      `CHK(wrc, 4'(wr_tab[i]))
      `CHK(dal, 5'((wr_tab[i] == 0) ? 0 : wr_tab[i] + 11))
      `CHK(rsv, (i == 0 || i == 7))
    end
    // Fixed and on-the-fly burst modes against reads and writes of both sizes; reserved code only written
    for (int b = 0; b < 4; b++) begin
      wr_mode(2'h0, 15'(16'h0210 | b));
      `CHK(blen, 2'(b))
      `CHK({ord, tmode, dll, pd, rsv}, {4'h0, b == 3})
      for (int k = 0; k < 4 && b < 3; k++) begin
        i_ctrl.access(k[1], k[0]);
        `CHK(av, 1'b1)
        `CHK(c4, (b == 2) || (b == 1 && !k[0]))
        `CHK(b8, (b == 0) || (b == 1 && k[0]))
        `CHK(po, (b == 2 && k[1]) ? 2'h2 : 2'h0)
        `CHK(term, k[1])
      end
    end
    @(negedge clock_in);
    `CHK(av, 1'b0)
    // Write leveling blocks termination even with nominal on
    nom_term = 1'b1;
    wlev = 1'b1;
    i_ctrl.access(1'b1, 1'b1);
    `CHK(term, 1'b0)
    wlev = 1'b0;
    // Pattern register: select ignored while disabled
    wr_mode(2'h3, 15'h0003);
    `CHK({pen, psel}, 3'h0)
    wr_mode(2'h3, 15'h0006);
    `CHK({pen, psel}, 3'h6)
    // Second warm reset at the end of the run clears every image
    i_ctrl.warm_reset();
    exp_img = '{15'h0000, 15'h0000, 15'h0000, 15'h0000};
    check_imgs();
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
